/* File: inc/axpd_pkg.sv */
// Shared widths, substitute values and timing-free constants for the port pair
package axpd_pkg;
  localparam int DATA_W = 32;
  localparam int STRB_W = DATA_W / 8;
  localparam int LANE_BITS = 2;
  localparam int ID_W = 4;
  localparam int SYS_AW = 32;
  localparam int MST_AW_DEF = 32;
  localparam int MST_AW_MAX = 64;
  localparam int MEM_AW_DEF = 12;
  localparam int LEN_W = 8;
  localparam int PROT_NS_BIT = 1;
  localparam logic [ID_W-1:0] ID_DEF = 4'h0;
  localparam logic [3:0] REGION_DEF = 4'h0;
  localparam logic [3:0] CACHE_DEF = 4'h0;
  localparam logic [3:0] QOS_DEF = 4'h0;
  localparam logic [LEN_W-1:0] LEN_DEF = 8'h00;
  localparam logic [2:0] SIZE_FULL = 3'h2;
  localparam logic [1:0] BURST_FIXED = 2'h0;
  localparam logic [1:0] BURST_INCR = 2'h1;
  localparam logic LOCK_DEF = 1'b0;
  localparam logic [2:0] PROT_DEF = 3'h0;
  localparam logic [STRB_W-1:0] STRB_DEF = {STRB_W{1'b1}};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

/* File: inc/axpd_if.sv */
// Five-channel memory port joining the master end and the slave end
`timescale 1ns/100ps
interface axpd_if;
  logic [axpd_pkg::ID_W-1:0] awid;
  logic [axpd_pkg::SYS_AW-1:0] awaddr;
  logic [3:0] awregion;
  logic [axpd_pkg::LEN_W-1:0] awlen;
  logic [2:0] awsize;
  logic [1:0] awburst;
  logic awlock;
  logic [3:0] awcache;
  logic [2:0] awprot;
  logic [3:0] awqos;
  logic awvalid;
  logic awready;
  logic [axpd_pkg::DATA_W-1:0] wdata;
  logic [axpd_pkg::STRB_W-1:0] wstrb;
  logic wlast;
  logic wvalid;
  logic wready;
  logic [axpd_pkg::ID_W-1:0] bid;
  logic [1:0] bresp;
  logic bvalid;
  logic bready;
  logic [axpd_pkg::ID_W-1:0] arid;
  logic [axpd_pkg::SYS_AW-1:0] araddr;
  logic [3:0] arregion;
  logic [axpd_pkg::LEN_W-1:0] arlen;
  logic [2:0] arsize;
  logic [1:0] arburst;
  logic arlock;
  logic [3:0] arcache;
  logic [2:0] arprot;
  logic [3:0] arqos;
  logic arvalid;
  logic arready;
  logic [axpd_pkg::ID_W-1:0] rid;
  logic [axpd_pkg::DATA_W-1:0] rdata;
  logic [1:0] rresp;
  logic rlast;
  logic rvalid;
  logic rready;

  modport mst (
    output awid, awaddr, awregion, awlen, awsize, awburst, awlock, awcache, awprot, awqos,
    output awvalid, wdata, wstrb, wlast, wvalid, bready,
    output arid, araddr, arregion, arlen, arsize, arburst, arlock, arcache, arprot, arqos,
    output arvalid, rready,
    input awready, wready, bid, bresp, bvalid, arready, rid, rdata, rresp, rlast, rvalid
  );
  modport slv (
    input awid, awaddr, awregion, awlen, awsize, awburst, awlock, awcache, awprot, awqos,
    input awvalid, wdata, wstrb, wlast, wvalid, bready,
    input arid, araddr, arregion, arlen, arsize, arburst, arlock, arcache, arprot, arqos,
    input arvalid, rready,
    output awready, wready, bid, bresp, bvalid, arready, rid, rdata, rresp, rlast, rvalid
  );
endinterface // axpd_if

/* File: rtl/axpd_addr_fit.sv */
// Address width adapter: zero-fills missing high bits, drops surplus ones
`timescale 1ns/100ps
module axpd_addr_fit #(
  parameter int IN_W = 32,
  parameter int OUT_W = 32
) (
  input wire logic [IN_W-1:0] addrIn, // Address from the narrower or wider side
  output logic [OUT_W-1:0] addrOut // Address fitted to the receiving width
);
  // Refuse widths the adapter cannot serve
  if (IN_W < 1 || OUT_W < 1) begin : g_bad_width
    $error("axpd_addr_fit: widths must be positive");
  end

  generate
    if (OUT_W > IN_W) begin : g_wide
      assign addrOut = {{(OUT_W-IN_W){1'b0}}, addrIn};
    end else begin : g_narrow
      assign addrOut = addrIn[OUT_W-1:0];
    end
  endgenerate
endmodule // axpd_addr_fit

/* File: rtl/axpd_mem_slave.sv */
// Memory slave end of the port, with local tie-offs for omitted inputs
`timescale 1ns/100ps
module axpd_mem_slave #(
  parameter int MEM_AW = axpd_pkg::MEM_AW_DEF,
  parameter bit HAS_STRB = 1'b1,
  parameter bit HAS_PROT = 1'b1,
  parameter bit HAS_RESP = 1'b1,
  parameter bit LITE = 1'b0
) (
  input wire logic ref_clk, // Global clock
  input wire logic arst_n, // Asynchronous reset, active low
  axpd_if.slv bus, // Port toward the master
  input wire logic nsBlock, // Refuse non-secure accesses when high
  output logic busy, // A transaction is in progress
  output logic errSeen // Sticky: an access was refused
);
  localparam int IDX_W = MEM_AW - axpd_pkg::LANE_BITS;
  localparam int DEPTH = 1 << IDX_W;

  // Refuse parameter values the logic cannot serve
  if (MEM_AW < axpd_pkg::MEM_AW_DEF) begin : g_bad_mem_aw
    $error("axpd_mem_slave: MEM_AW must cover at least 4kB");
  end
  if (LITE && axpd_pkg::DATA_W != 32 && axpd_pkg::DATA_W != 64) begin : g_bad_lite
    $error("axpd_mem_slave: Lite data width must be 32 or 64");
  end

  typedef enum {S_IDLE, S_AWTAKE, S_WDATA, S_WRESP, S_ARTAKE, S_RDATA} axpd_slv_e;

  typedef struct packed {
    axpd_slv_e st;
    logic awready;
    logic wready;
    logic bvalid;
    logic arready;
    logic rvalid;
    logic rlast;
    logic [1:0] resp;
    logic [axpd_pkg::ID_W-1:0] id;
    logic [axpd_pkg::DATA_W-1:0] rdata;
    logic [IDX_W-1:0] idx;
    logic [axpd_pkg::LEN_W-1:0] len;
    logic [axpd_pkg::LEN_W-1:0] cnt;
    logic [1:0] burst;
    logic err;
    logic busy;
    logic errSeen;
  } axpd_slv_s;

  axpd_slv_s s_r;
  axpd_slv_s s_nxt;
  logic [axpd_pkg::DATA_W-1:0] mem [DEPTH];

  // ****************************************************************
  // Input tie-offs and address fitting
  // ****************************************************************
  logic [MEM_AW-1:0] memAw;
  logic [MEM_AW-1:0] memAr;
  logic [axpd_pkg::STRB_W-1:0] strbIn;
  logic [2:0] awProtIn;
  logic [2:0] arProtIn;
  logic [axpd_pkg::LEN_W-1:0] awLenIn;
  logic [axpd_pkg::LEN_W-1:0] arLenIn;
  logic awRefuse;
  logic arRefuse;
  logic memWe;
  logic [IDX_W-1:0] idxStep;

  axpd_addr_fit #(.IN_W(axpd_pkg::SYS_AW), .OUT_W(MEM_AW)) u_fit_aw (
    .addrIn(bus.awaddr),
    .addrOut(memAw)
  );
  axpd_addr_fit #(.IN_W(axpd_pkg::SYS_AW), .OUT_W(MEM_AW)) u_fit_ar (
    .addrIn(bus.araddr),
    .addrOut(memAr)
  );

  assign strbIn = HAS_STRB ? bus.wstrb : axpd_pkg::STRB_DEF;
  assign awProtIn = HAS_PROT ? bus.awprot : axpd_pkg::PROT_DEF;
  assign arProtIn = HAS_PROT ? bus.arprot : axpd_pkg::PROT_DEF;
  assign awLenIn = LITE ? axpd_pkg::LEN_DEF : bus.awlen;
  assign arLenIn = LITE ? axpd_pkg::LEN_DEF : bus.arlen;
  // Lock and cache inputs are never looked at: no exclusive, one cache policy
  assign awRefuse = nsBlock && awProtIn[axpd_pkg::PROT_NS_BIT];
  assign arRefuse = nsBlock && arProtIn[axpd_pkg::PROT_NS_BIT];
  assign idxStep = (s_r.burst == axpd_pkg::BURST_FIXED) ? s_r.idx : s_r.idx + 1'b1;
  assign memWe = (s_r.st == S_WDATA) && bus.wvalid && s_r.wready && !s_r.err;

  // ****************************************************************
  // Transaction sequencer
  // ****************************************************************
  always_comb begin
    s_nxt = s_r;
    case (s_r.st)
      S_IDLE: begin
        if (bus.awvalid) begin
          s_nxt.awready = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = S_AWTAKE;
        end else if (bus.arvalid) begin
          s_nxt.arready = 1'b1;
          s_nxt.busy = 1'b1;
          s_nxt.st = S_ARTAKE;
        end
      end
      S_AWTAKE: begin
        s_nxt.awready = 1'b0;
        s_nxt.wready = 1'b1;
        s_nxt.idx = memAw[MEM_AW-1:axpd_pkg::LANE_BITS];
        s_nxt.len = awLenIn;
        s_nxt.cnt = axpd_pkg::LEN_DEF;
        s_nxt.burst = bus.awburst;
        s_nxt.id = bus.awid;
        s_nxt.err = HAS_PROT && awRefuse;
        s_nxt.st = S_WDATA;
      end
      S_WDATA: begin
        if (bus.wvalid) begin
          if (s_r.cnt == s_r.len) begin
            s_nxt.wready = 1'b0;
            s_nxt.bvalid = 1'b1;
            s_nxt.resp = (HAS_RESP && s_r.err) ? axpd_pkg::RESP_SLVERR
                                               : axpd_pkg::RESP_OKAY;
            s_nxt.errSeen = s_r.errSeen | s_r.err;
            s_nxt.st = S_WRESP;
          end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            s_nxt.idx = idxStep;
          end
        end
      end
      S_WRESP: begin
        if (bus.bready) begin
          s_nxt.bvalid = 1'b0;
          s_nxt.busy = 1'b0;
          s_nxt.st = S_IDLE;
        end
      end
      S_ARTAKE: begin
        s_nxt.arready = 1'b0;
        s_nxt.idx = memAr[MEM_AW-1:axpd_pkg::LANE_BITS];
        s_nxt.len = arLenIn;
        s_nxt.cnt = axpd_pkg::LEN_DEF;
        s_nxt.burst = bus.arburst;
        s_nxt.id = bus.arid;
        s_nxt.err = HAS_PROT && arRefuse;
        s_nxt.errSeen = s_r.errSeen | (HAS_PROT && arRefuse);
        s_nxt.rdata = (HAS_PROT && arRefuse) ? '0
                    : mem[memAr[MEM_AW-1:axpd_pkg::LANE_BITS]];
        s_nxt.resp = (HAS_RESP && HAS_PROT && arRefuse) ? axpd_pkg::RESP_SLVERR
                                                        : axpd_pkg::RESP_OKAY;
        s_nxt.rlast = (arLenIn == axpd_pkg::LEN_DEF);
        s_nxt.rvalid = 1'b1;
        s_nxt.st = S_RDATA;
      end
      S_RDATA: begin
        if (bus.rready) begin
          if (s_r.rlast) begin
            s_nxt.rvalid = 1'b0;
            s_nxt.rlast = 1'b0;
            s_nxt.busy = 1'b0;
            s_nxt.st = S_IDLE;
          end else begin
            s_nxt.cnt = s_r.cnt + 1'b1;
            s_nxt.idx = idxStep;
            s_nxt.rdata = s_r.err ? '0 : mem[idxStep];
            s_nxt.rlast = ((s_r.cnt + 1'b1) == s_r.len);
          end
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '{st: S_IDLE, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Storage with byte-lane enables
  // ****************************************************************
  always_ff @(posedge ref_clk) begin
    if (memWe) begin
      for (int b = 0; b < axpd_pkg::STRB_W; b++) begin
        if (strbIn[b]) begin
          mem[s_r.idx][8*b +: 8] <= bus.wdata[8*b +: 8];
        end
      end
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign bus.awready = s_r.awready;
  assign bus.wready = s_r.wready;
  assign bus.bvalid = s_r.bvalid;
  assign bus.bresp = s_r.resp;
  assign bus.bid = s_r.id;
  assign bus.arready = s_r.arready;
  assign bus.rvalid = s_r.rvalid;
  assign bus.rdata = s_r.rdata;
  assign bus.rresp = s_r.resp;
  assign bus.rid = s_r.id;
  assign bus.rlast = s_r.rlast;
  assign busy = s_r.busy;
  assign errSeen = s_r.errSeen;
endmodule // axpd_mem_slave

/* File: rtl/axpd_master.sv */
// Master end of the port: drives substitute values on outputs it does not vary
`timescale 1ns/100ps
module axpd_master #(
  parameter int MST_AW = axpd_pkg::MST_AW_DEF,
  parameter bit HAS_STRB = 1'b1,
  parameter bit HAS_RESP = 1'b1,
  parameter bit LITE = 1'b0
) (
  input wire logic ref_clk, // Global clock
  input wire logic arst_n, // Asynchronous reset, active low
  axpd_if.mst bus, // Port toward the slave
  input wire logic cmdValid, // Command offered
  output logic cmdReady, // Command can be taken
  input wire logic cmdWrite, // 1 write, 0 read
  input wire logic [MST_AW-1:0] cmdAddr, // Start byte address
  input wire logic [axpd_pkg::LEN_W-1:0] cmdLen, // Beats minus one
  input wire logic [2:0] cmdProt, // Protection attributes, bit 1 non-secure
  input wire logic [axpd_pkg::STRB_W-1:0] cmdStrb, // Byte lanes for every beat
  input wire logic [axpd_pkg::DATA_W-1:0] wrData, // Data for the next write beat
  output logic beatDone, // Pulse: write beat accepted, present next data
  output logic [axpd_pkg::DATA_W-1:0] rdData, // Read beat data
  output logic rdValid, // Pulse: read beat delivered
  output logic rdLast, // With rdValid: final beat by count
  output logic done, // Pulse: transaction finished
  output logic rspErr // With done: error response seen
);
  // Refuse address widths outside the supported span
  if (MST_AW < 1 || MST_AW > axpd_pkg::MST_AW_MAX) begin : g_bad_aw
    $error("axpd_master: MST_AW must be 1 to 64");
  end

  typedef enum {M_IDLE, M_AW, M_W, M_WGAP, M_B, M_AR, M_R} axpd_mst_e;

  typedef struct packed {
    axpd_mst_e st;
    logic cmdReady;
    logic awvalid;
    logic wvalid;
    logic wlast;
    logic bready;
    logic arvalid;
    logic rready;
    logic [axpd_pkg::SYS_AW-1:0] addr;
    logic [axpd_pkg::LEN_W-1:0] len;
    logic [axpd_pkg::LEN_W-1:0] cnt;
    logic [2:0] prot;
    logic [axpd_pkg::STRB_W-1:0] strb;
    logic [axpd_pkg::DATA_W-1:0] wdata;
    logic [axpd_pkg::DATA_W-1:0] rdData;
    logic rdValid;
    logic rdLast;
    logic beatDone;
    logic done;
    logic err;
  } axpd_mst_s;

  axpd_mst_s m_r;
  axpd_mst_s m_nxt;
  logic [axpd_pkg::SYS_AW-1:0] sysAddr;

  axpd_addr_fit #(.IN_W(MST_AW), .OUT_W(axpd_pkg::SYS_AW)) u_fit (
    .addrIn(cmdAddr),
    .addrOut(sysAddr)
  );

  always_comb begin
    m_nxt = m_r;
    m_nxt.beatDone = 1'b0;
    m_nxt.rdValid = 1'b0;
    m_nxt.rdLast = 1'b0;
    m_nxt.done = 1'b0;
    case (m_r.st)
      M_IDLE: begin
        if (cmdValid && m_r.cmdReady) begin
          m_nxt.cmdReady = 1'b0;
          m_nxt.addr = sysAddr;
          m_nxt.len = LITE ? axpd_pkg::LEN_DEF : cmdLen;
          m_nxt.cnt = axpd_pkg::LEN_DEF;
          m_nxt.prot = cmdProt;
          m_nxt.strb = HAS_STRB ? cmdStrb : axpd_pkg::STRB_DEF;
          m_nxt.err = 1'b0;
          m_nxt.awvalid = cmdWrite;
          m_nxt.arvalid = !cmdWrite;
          m_nxt.st = cmdWrite ? M_AW : M_AR;
        end
      end
      M_AW: begin
        if (bus.awready) begin
          m_nxt.awvalid = 1'b0;
          m_nxt.wvalid = 1'b1;
          m_nxt.wdata = wrData;
          m_nxt.wlast = (m_r.len == axpd_pkg::LEN_DEF);
          m_nxt.st = M_W;
        end
      end
      M_W: begin
        if (bus.wready) begin
          m_nxt.wvalid = 1'b0;
          m_nxt.beatDone = 1'b1;
          if (m_r.wlast) begin
            m_nxt.wlast = 1'b0;
            m_nxt.bready = 1'b1;
            m_nxt.st = M_B;
          end else begin
            m_nxt.cnt = m_r.cnt + 1'b1;
            m_nxt.st = M_WGAP;
          end
        end
      end
      M_WGAP: begin
        m_nxt.wvalid = 1'b1;
        m_nxt.wdata = wrData;
        m_nxt.wlast = (m_r.cnt == m_r.len);
        m_nxt.st = M_W;
      end
      M_B: begin
        if (bus.bvalid) begin
          m_nxt.bready = 1'b0;
          m_nxt.err = HAS_RESP && (bus.bresp != axpd_pkg::RESP_OKAY);
          m_nxt.done = 1'b1;
          m_nxt.cmdReady = 1'b1;
          m_nxt.st = M_IDLE;
        end
      end
      M_AR: begin
        if (bus.arready) begin
          m_nxt.arvalid = 1'b0;
          m_nxt.rready = 1'b1;
          m_nxt.st = M_R;
        end
      end
      M_R: begin
        if (bus.rvalid) begin
          m_nxt.rdData = bus.rdata;
          m_nxt.rdValid = 1'b1;
          m_nxt.rdLast = (m_r.cnt == m_r.len);
          m_nxt.err = m_r.err | (HAS_RESP && (bus.rresp != axpd_pkg::RESP_OKAY));
          if (m_r.cnt == m_r.len) begin
            m_nxt.rready = 1'b0;
            m_nxt.done = 1'b1;
            m_nxt.cmdReady = 1'b1;
            m_nxt.st = M_IDLE;
          end else begin
            m_nxt.cnt = m_r.cnt + 1'b1;
          end
        end
      end
      default: begin
        m_nxt.st = M_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      m_r <= '{st: M_IDLE, cmdReady: 1'b1, default: '0};
    end else begin
      m_r <= m_nxt;
    end
  end

  // ****************************************************************
  // Outputs: fixed fields carry their substitute values
  // ****************************************************************
  assign bus.awid = axpd_pkg::ID_DEF;
  assign bus.awaddr = m_r.addr;
  assign bus.awregion = axpd_pkg::REGION_DEF;
  assign bus.awlen = m_r.len;
  assign bus.awsize = axpd_pkg::SIZE_FULL;
  assign bus.awburst = axpd_pkg::BURST_INCR;
  assign bus.awlock = axpd_pkg::LOCK_DEF;
  assign bus.awcache = axpd_pkg::CACHE_DEF;
  assign bus.awprot = m_r.prot;
  assign bus.awqos = axpd_pkg::QOS_DEF;
  assign bus.awvalid = m_r.awvalid;
  assign bus.wdata = m_r.wdata;
  assign bus.wstrb = m_r.strb;
  assign bus.wlast = m_r.wlast;
  assign bus.wvalid = m_r.wvalid;
  assign bus.bready = m_r.bready;
  assign bus.arid = axpd_pkg::ID_DEF;
  assign bus.araddr = m_r.addr;
  assign bus.arregion = axpd_pkg::REGION_DEF;
  assign bus.arlen = m_r.len;
  assign bus.arsize = axpd_pkg::SIZE_FULL;
  assign bus.arburst = axpd_pkg::BURST_INCR;
  assign bus.arlock = axpd_pkg::LOCK_DEF;
  assign bus.arcache = axpd_pkg::CACHE_DEF;
  assign bus.arprot = m_r.prot;
  assign bus.arqos = axpd_pkg::QOS_DEF;
  assign bus.arvalid = m_r.arvalid;
  assign bus.rready = m_r.rready;
  assign cmdReady = m_r.cmdReady;
  assign beatDone = m_r.beatDone;
  assign rdData = m_r.rdData;
  assign rdValid = m_r.rdValid;
  assign rdLast = m_r.rdLast;
  assign done = m_r.done;
  assign rspErr = m_r.err;
endmodule // axpd_master

/* File: dv/axpd_checker.sv */
// Protocol checker for the master and memory slave port pair
`timescale 1ns/100ps
module axpd_checker (
  input wire logic ref_clk, // Clock
  input wire logic arst_n, // Reset, active low
  input wire logic [axpd_pkg::LEN_W-1:0] awlen, // AW length
  input wire logic [2:0] awsize, // AW size
  input wire logic [1:0] awburst, // AW burst
  input wire logic awlock, // AW lock
  input wire logic [3:0] awcache, // AW cache
  input wire logic [2:0] awprot, // AW protection
  input wire logic awvalid, // AW valid
  input wire logic awready, // AW ready
  input wire logic wlast, // W last
  input wire logic wvalid, // W valid
  input wire logic wready, // W ready
  input wire logic [1:0] bresp, // B response
  input wire logic bvalid, // B valid
  input wire logic [axpd_pkg::LEN_W-1:0] arlen, // AR length
  input wire logic [2:0] arsize, // AR size
  input wire logic [1:0] arburst, // AR burst
  input wire logic arlock, // AR lock
  input wire logic [3:0] arcache, // AR cache
  input wire logic [2:0] arprot, // AR protection
  input wire logic arvalid, // AR valid
  input wire logic arready, // AR ready
  input wire logic rlast, // R last
  input wire logic rvalid, // R valid
  input wire logic rready // R ready
);
  // ********************
  // Beat counters
  // ********************
  logic [8:0] wCnt;
  logic [8:0] rCnt;
  logic [7:0] awLenR;
  logic [7:0] arLenR;
  logic awNsR;
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      wCnt <= 9'h000;
      rCnt <= 9'h000;
      awLenR <= 8'h00;
      arLenR <= 8'h00;
      awNsR <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        awLenR <= awlen;
        awNsR <= awprot[1];
        wCnt <= 9'h000;
      end else if (wvalid && wready) begin
        wCnt <= wCnt + 9'h001;
      end
      if (arvalid && arready) begin
        arLenR <= arlen;
        rCnt <= 9'h000;
      end else if (rvalid && rready) begin
        rCnt <= rCnt + 9'h001;
      end
    end
  end
  // ********************
  // Assertions
  // ********************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  a_aw_subst_value: assert property (awvalid |->
    {awsize, awburst, awlock, awcache} ==
    {axpd_pkg::SIZE_FULL, axpd_pkg::BURST_INCR, axpd_pkg::LOCK_DEF, axpd_pkg::CACHE_DEF})
    else $error("AW substitute value wrong");
  a_ar_subst_value: assert property (arvalid |->
    {arsize, arburst, arlock, arcache} ==
    {axpd_pkg::SIZE_FULL, axpd_pkg::BURST_INCR, axpd_pkg::LOCK_DEF, axpd_pkg::CACHE_DEF})
    else $error("AR substitute value wrong");
  a_aw_prot_hold: assert property (awvalid && !awready |=> awvalid && $stable(awprot))
    else $error("AW protection not held");
  a_ar_prot_hold: assert property (arvalid && !arready |=> arvalid && $stable(arprot))
    else $error("AR protection not held");
  a_bvalid_beat_count: assert property ($rose(bvalid) |->
    wCnt == {1'b0, awLenR} + 9'h001)
    else $error("Write response before all beats");
  a_wlast_beat_count: assert property (wvalid |-> wlast == (wCnt == {1'b0, awLenR}))
    else $error("Write last on wrong beat");
  a_rlast_beat_count: assert property (rvalid |-> rlast == (rCnt == {1'b0, arLenR}))
    else $error("Read last on wrong beat");
  a_secure_resp_okay: assert property (bvalid && !awNsR |-> bresp == 2'h0)
    else $error("Secure write not OKAY");
  cp_long_write: cover property (bvalid && awLenR == 8'hff);
  cp_read_last: cover property (rvalid && rready && rlast);
  cp_refused: cover property (bvalid && bresp == 2'h2);
endmodule // axpd_checker

/* File: dv/axi_port_signal_defaults_test.sv */
// Self-checking bench for the master and memory slave pair
`timescale 1ns/100ps
`define CHK(act, exp) begin samples_checked++; \
  if ((act) !== (exp) || $isunknown(act)) begin n_fail++; \
  $display("[FAIL] %0t got %h exp %h", $time, (act), (exp)); end end
module axi_port_signal_defaults_test;
  logic ref_clk;
  logic arst_n;
  logic cmdValid;
  logic cmdReady;
  logic cmdWrite;
  logic [31:0] cmdAddr;
  logic [7:0] cmdLen;
  logic [2:0] cmdProt;
  logic [3:0] cmdStrb;
  logic [31:0] wrData;
  logic [31:0] rdData;
  logic beatDone;
  logic rdValid;
  logic rdLast;
  logic done;
  logic rspErr;
  logic nsBlock;
  logic errSeen;
  logic busy;
  logic errExp;
  logic [31:0] mem [1024];
  int n_fail;
  int samples_checked;
  int i;
  int seedDummy;
  axpd_if axpd_if_i ();
  axpd_master axpd_master_i (.ref_clk(ref_clk), .arst_n(arst_n), .bus(axpd_if_i.mst),
    .cmdValid(cmdValid), .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr),
    .cmdLen(cmdLen), .cmdProt(cmdProt), .cmdStrb(cmdStrb), .wrData(wrData),
    .beatDone(beatDone), .rdData(rdData), .rdValid(rdValid), .rdLast(rdLast),
    .done(done), .rspErr(rspErr));
  axpd_mem_slave axpd_mem_slave_i (.ref_clk(ref_clk), .arst_n(arst_n), .bus(axpd_if_i.slv),
    .nsBlock(nsBlock), .busy(busy), .errSeen(errSeen));
  axpd_checker axpd_checker_i (.ref_clk(ref_clk), .arst_n(arst_n), .awlen(axpd_if_i.awlen),
    .awsize(axpd_if_i.awsize), .awburst(axpd_if_i.awburst), .awlock(axpd_if_i.awlock),
    .awcache(axpd_if_i.awcache), .awprot(axpd_if_i.awprot), .awvalid(axpd_if_i.awvalid),
    .awready(axpd_if_i.awready), .wlast(axpd_if_i.wlast), .wvalid(axpd_if_i.wvalid),
    .wready(axpd_if_i.wready), .bresp(axpd_if_i.bresp), .bvalid(axpd_if_i.bvalid),
    .arlen(axpd_if_i.arlen), .arsize(axpd_if_i.arsize), .arburst(axpd_if_i.arburst),
    .arlock(axpd_if_i.arlock), .arcache(axpd_if_i.arcache), .arprot(axpd_if_i.arprot),
    .arvalid(axpd_if_i.arvalid), .arready(axpd_if_i.arready), .rlast(axpd_if_i.rlast),
    .rvalid(axpd_if_i.rvalid), .rready(axpd_if_i.rready));
  always #25 ref_clk = ~ref_clk;
  // ********************
  // Expectation and transfer tasks
  // ********************
  function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n, logic [3:0] s);
    for (int j = 0; j < 4; j++) begin
      if (s[j]) o[8*j +: 8] = n[8*j +: 8];
    end
    return o;
  endfunction
  task automatic results();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] n,
      input logic [2:0] p, input logic [3:0] s, input logic ns);
    logic [31:0] d [257];
    logic bad;
    int b;
    int t;
    int k;
    for (k = 0; k < 257; k++) d[k] = $urandom;
    bad = p[1] && ns;
    b = 0;
    @(posedge ref_clk);
    #1;
    nsBlock = ns;
    cmdWrite = w;
    cmdAddr = a;
    cmdLen = n;
    cmdProt = p;
    cmdStrb = s;
    wrData = d[0];
    cmdValid = 1'b1;
    while (cmdReady !== 1'b1) begin
      @(posedge ref_clk);
      #1;
    end
    @(posedge ref_clk);
    #1;
    cmdValid = 1'b0;
    for (t = 0; t < 3000; t++) begin
      k = int'(((a >> 2) + 32'(b)) % 32'd1024);
      if (beatDone === 1'b1) begin
        `CHK(busy, 1'b1)
        if (!bad) mem[k] = merge(mem[k], d[b], s);
        b++;
        wrData = d[b];
      end
      if (rdValid === 1'b1) begin
        `CHK(rdData, bad ? 32'h0 : mem[k])
        `CHK(rdLast, 1'(b == int'(n)))
        b++;
      end
      if (done === 1'b1) break;
      @(posedge ref_clk);
      #1;
    end
    errExp = errExp | bad;
    `CHK(t < 3000, 1'b1)
    `CHK(b, int'(n) + 1)
    `CHK(busy, 1'b0)
    `CHK(rspErr, bad)
    `CHK(errSeen, errExp)
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    #1000000;
    n_fail++;
    results();
  end
  initial begin
    ref_clk = 1'b0;
    arst_n = 1'b0;
    {cmdValid, cmdWrite, cmdAddr, cmdLen, cmdProt, cmdStrb, wrData, nsBlock} = '0;
    errExp = 1'b0;
    n_fail = 0;
    samples_checked = 0;
    seedDummy = $urandom(32'hc766bdb8);
    repeat (4) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    for (i = 0; i < 4; i++) xfer(1'b1, 32'hfffff000 + 32'(i) * 32'h400, 8'hff, 3'h0, 4'hf, 1'b0);
    for (i = 0; i < 4; i++) xfer(1'b0, 32'h00005003 + 32'(i) * 32'h400, 8'hff, 3'h2, 4'hf, 1'b0);
    for (i = 0; i < 8; i++) xfer(i[0], 32'h10 + 32'(i) * 32'h4, 8'h00, 3'(i), 4'h5, 1'b1);
    for (i = 0; i < 48; i++) begin
      xfer(1'($urandom), $urandom, 8'($urandom % 16), 3'($urandom), 4'($urandom), 1'($urandom));
    end
    results();
  end
endmodule // axi_port_signal_defaults_test
